//--- shared/pwm_map.vh
// Register map, field layout and reset values of the eight channel waveform timer
`ifndef PWM_MAP_VH
`define PWM_MAP_VH

// Bus widths and channel count
`define PWM_ADDR_W 6
`define PWM_DATA_W 8
`define PWM_CH_N 8
`define PWM_PAIR_N 4
`define PWM_WIDE_W 16

// Control and status registers, one bit per channel, JOIN one bit per channel pair
`define PWM_REG_ENABLE 6'h00
`define PWM_REG_POLARITY 6'h01
`define PWM_REG_CENTER 6'h02
`define PWM_REG_JOIN 6'h03
`define PWM_REG_PCM 6'h04
`define PWM_REG_OUTSTAT 6'h05

// Banks of eight: address bits 5:3 pick the bank, bits 2:0 the channel
`define PWM_BANK_MSB 5
`define PWM_BANK_LSB 3
`define PWM_CH_MSB 2
`define PWM_BANK_PERIOD 3'h1
`define PWM_BANK_DUTY 3'h2
`define PWM_BANK_COUNT 3'h3

// Reset values
`define PWM_RST_ENABLE 8'h00
`define PWM_RST_POLARITY 8'hff
`define PWM_RST_CENTER 8'h00
`define PWM_RST_PCM 8'h00
`define PWM_RST_JOIN 4'h0
`define PWM_RST_PERIOD 8'hff
`define PWM_RST_DUTY 8'h00
`define PWM_BYTE_ZERO 8'h00

`endif

//--- core/pwm_channel.v
// One waveform channel: counter, buffered period and duty, waveform flip-flop
`timescale 1ns/100ps
module pwm_channel #(
	parameter W = 16
) (
	input wire clk_sys,
	input wire rst,
	input wire enable,
	input wire active_high,
	input wire center,
	input wire pcm,
	input wire [W-1:0] period,
	input wire [W-1:0] duty,
	output wire [W-1:0] count,
	output reg wave_q
);
	localparam [W-1:0] ZERO = {W{1'b0}};
	localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

	reg [W-1:0] cnt_q;
	reg [W-1:0] cnt_d;
	reg [W-1:0] per_q;
	reg [W-1:0] duty_q;
	reg down_q;
	reg down_d;
	reg load;

	// Accumulator arithmetic for the density mode
	wire [W:0] acc_sum = {1'b0, cnt_q} + {1'b0, duty_q};
	wire [W:0] acc_left = acc_sum - {1'b0, per_q};
	wire acc_over = acc_sum >= {1'b0, per_q};

	// Saturated duty settings override every mode
	wire none = duty_q == ZERO;
	wire full = !none && (duty_q >= per_q);
	wire act = none ? 1'b0 : full ? 1'b1 : pcm ? acc_over : (cnt_q < duty_q);

	// Next counter state; load takes new period and duty at a boundary, every cycle in density mode or when disabled
	always @* begin
		cnt_d = cnt_q;
		down_d = down_q;
		load = 1'b0;
		if (!enable) begin
			cnt_d = ZERO;
			down_d = 1'b0;
			load = 1'b1;
		end else if (pcm) begin
			load = 1'b1;
			if (full || none)
				cnt_d = ZERO;
			else if (acc_over)
				cnt_d = acc_left[W-1:0];
			else
				cnt_d = acc_sum[W-1:0];
		end else if (center) begin
			if (!down_q) begin
				if (cnt_q >= per_q) begin
					down_d = 1'b1;
					cnt_d = (cnt_q == ZERO) ? ZERO : cnt_q - ONE;
				end else begin
					cnt_d = cnt_q + ONE;
				end
			end else if (cnt_q == ZERO) begin
				down_d = 1'b0;
				load = 1'b1;
				cnt_d = ONE;
			end else begin
				cnt_d = cnt_q - ONE;
			end
		end else begin
			if (cnt_q + ONE >= per_q) begin
				cnt_d = ZERO;
				load = 1'b1;
			end else begin
				cnt_d = cnt_q + ONE;
			end
		end
	end

	// State registers and the waveform with its polarity
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_q <= ZERO;
			down_q <= 1'b0;
			per_q <= ZERO;
			duty_q <= ZERO;
			wave_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			down_q <= down_d;
			if (load) begin
				per_q <= period;
				duty_q <= duty;
			end
			wave_q <= enable ? (act ~^ active_high) : ~active_high;
		end
	end

	assign count = cnt_q;
endmodule // pwm_channel

//--- core/pwm_timer.v
// Eight channel waveform timer: register file, pairing logic and output flops
`timescale 1ns/100ps
`include "pwm_map.vh"
module pwm_timer #(
	parameter CH_N = `PWM_CH_N,
	parameter WIDE_W = `PWM_WIDE_W
) (
	input wire clk_sys,
	input wire rst,
	input wire [`PWM_ADDR_W-1:0] reg_addr,
	input wire [`PWM_DATA_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [`PWM_DATA_W-1:0] reg_rdata_q,
	output reg [CH_N-1:0] pwm_out_q
);
	// Bank decode, used for writes and reads alike
	function bank_hit;
		input [`PWM_ADDR_W-1:0] addr;
		input [2:0] bank;
		begin
			bank_hit = addr[`PWM_BANK_MSB:`PWM_BANK_LSB] == bank;
		end
	endfunction

	// Control registers
	reg [CH_N-1:0] en_q;
	reg [CH_N-1:0] pol_q;
	reg [CH_N-1:0] ctr_q;
	reg [CH_N-1:0] pcm_q;
	reg [CH_N/2-1:0] join_q;

	// Period and duty bytes, one per channel
	reg [`PWM_DATA_W-1:0] per_q [0:CH_N-1];
	reg [`PWM_DATA_W-1:0] duty_q [0:CH_N-1];

	// Channel outputs
	wire [CH_N-1:0] wave;
	wire [WIDE_W-1:0] cnt_w [0:CH_N-1];
	wire [`PWM_DATA_W-1:0] cnt_rd [0:CH_N-1];

	wire [`PWM_CH_MSB:0] sel = reg_addr[`PWM_CH_MSB:0];
	integer k;

	// Register writes
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			en_q <= `PWM_RST_ENABLE;
			pol_q <= `PWM_RST_POLARITY;
			ctr_q <= `PWM_RST_CENTER;
			pcm_q <= `PWM_RST_PCM;
			join_q <= `PWM_RST_JOIN;
			for (k = 0; k < CH_N; k = k + 1) begin
				per_q[k] <= `PWM_RST_PERIOD;
				duty_q[k] <= `PWM_RST_DUTY;
			end
		end else if (reg_wr) begin
			case (reg_addr)
				`PWM_REG_ENABLE: en_q <= reg_wdata;
				`PWM_REG_POLARITY: pol_q <= reg_wdata;
				`PWM_REG_CENTER: ctr_q <= reg_wdata;
				`PWM_REG_PCM: pcm_q <= reg_wdata;
				`PWM_REG_JOIN: join_q <= reg_wdata[CH_N/2-1:0];
				default: begin
					if (bank_hit(reg_addr, `PWM_BANK_PERIOD))
						per_q[sel] <= reg_wdata;
					else if (bank_hit(reg_addr, `PWM_BANK_DUTY))
						duty_q[sel] <= reg_wdata;
				end
			endcase
		end
	end

	// One channel per index; a joined pair runs in its odd member
	genvar i;
	generate
		for (i = 0; i < CH_N; i = i + 1) begin : g_ch
			localparam ODD = i % 2;
			localparam LOW = i - ODD;
			localparam HIGH = i + 1 - ODD;
			wire joined = join_q[i/2];
			wire wide = joined && (ODD == 1);
			wire [WIDE_W-1:0] period;
			wire [WIDE_W-1:0] duty;
			wire run;

			// Odd register holds the high byte of a joined pair
			assign period = wide ? {per_q[i], per_q[LOW]} : {`PWM_BYTE_ZERO, per_q[i]};
			assign duty = wide ? {duty_q[i], duty_q[LOW]} : {`PWM_BYTE_ZERO, duty_q[i]};
			// Even member of a joined pair idles at its inactive level
			assign run = en_q[i] && !(joined && (ODD == 0));

			pwm_channel #(
				.W(WIDE_W)
			) u_ch (
				.clk_sys(clk_sys),
				.rst(rst),
				.enable(run),
				.active_high(pol_q[i]),
				.center(ctr_q[i]),
				.pcm(pcm_q[i]),
				.period(period),
				.duty(duty),
				.count(cnt_w[i]),
				.wave_q(wave[i])
			);

			// Counter readback: joined pair shows high byte on odd, low on even
			assign cnt_rd[i] = !joined ? cnt_w[i][`PWM_DATA_W-1:0] :
				(ODD == 1) ? cnt_w[i][WIDE_W-1:`PWM_DATA_W] :
				cnt_w[HIGH][`PWM_DATA_W-1:0];
		end
	endgenerate

	// Read data selection
	reg [`PWM_DATA_W-1:0] rd_d;
	always @* begin
		rd_d = `PWM_BYTE_ZERO;
		case (reg_addr)
			`PWM_REG_ENABLE: rd_d = en_q;
			`PWM_REG_POLARITY: rd_d = pol_q;
			`PWM_REG_CENTER: rd_d = ctr_q;
			`PWM_REG_PCM: rd_d = pcm_q;
			`PWM_REG_JOIN: rd_d = {{(`PWM_DATA_W-CH_N/2){1'b0}}, join_q};
			`PWM_REG_OUTSTAT: rd_d = pwm_out_q;
			default: begin
				if (bank_hit(reg_addr, `PWM_BANK_PERIOD))
					rd_d = per_q[sel];
				else if (bank_hit(reg_addr, `PWM_BANK_DUTY))
					rd_d = duty_q[sel];
				else if (bank_hit(reg_addr, `PWM_BANK_COUNT))
					rd_d = cnt_rd[sel];
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge clk_sys or posedge rst) begin
		if (rst)
			reg_rdata_q <= `PWM_BYTE_ZERO;
		else
			reg_rdata_q <= reg_rd ? rd_d : `PWM_BYTE_ZERO;
	end

	// Output pins straight from flip-flops
	always @(posedge clk_sys or posedge rst) begin
		if (rst)
			pwm_out_q <= {CH_N{1'b0}};
		else
			pwm_out_q <= wave;
	end
endmodule // pwm_timer

//--- sim/pwm_load.sv
// Load model: counts the high cycles of each waveform output
`timescale 1ns/100ps
module pwm_load (
	input wire clk_sys,
	input wire clr,
	input wire [7:0] pwm_out_q,
	output reg [127:0] hi_cnt
);
	integer i;
	// High time per channel, cleared by the bench
	always @(posedge clk_sys) begin
		for (i = 0; i < 8; i = i + 1) begin
			if (clr) hi_cnt[16*i+:16] <= 16'h0000;
			else hi_cnt[16*i+:16] <= hi_cnt[16*i+:16] + pwm_out_q[i];
		end
	end
endmodule // pwm_load

//--- sim/pwm_timer_properties.sv
// Checker: register and waveform relations at the timer ports
`timescale 1ns/100ps
module pwm_timer_properties (
	input wire clk_sys,
	input wire rst,
	input wire [5:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata_q,
	input wire [7:0] pwm_out_q
);
	reg [7:0] sh_q [0:31];
	reg [9:0] cnt_q;
	reg [7:0] idle, act, jm;
	integer i, k;
	wire rw = reg_addr < 5 || (reg_addr > 7 && reg_addr < 24);
	wire [7:0] pol = sh_q[1];
	wire [7:0] exp_rd = sh_q[reg_addr[4:0]];
	wire quiet = cnt_q == 10'h258;
	// Shadow registers, quiet time since the last write
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (i = 0; i < 32; i = i + 1) sh_q[i] <= (i == 1 || i / 8 == 1) ? 8'hff : 8'h00;
			cnt_q <= 10'h000;
		end else begin
			if (reg_wr && rw) sh_q[reg_addr[4:0]] <= reg_addr == 3 ? reg_wdata & 8'h0f : reg_wdata;
			if (reg_wr) cnt_q <= 10'h000;
			else if (cnt_q != 10'h258) cnt_q <= cnt_q + 10'h001;
		end
	end
	// Channels whose level is fixed by the settings
	always @* begin
		for (k = 0; k < 8; k = k + 1) begin
			jm[k] = !k[0] && sh_q[3][k/2];
			idle[k] = !jm[k] && (!sh_q[0][k] || (sh_q[16+k] == 0 && !sh_q[3][k/2]));
			act[k] = sh_q[0][k] && !sh_q[3][k/2] && sh_q[16+k] != 0 && sh_q[16+k] >= sh_q[8+k];
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_reset_quiet: assert property (disable iff (1'b0) rst |-> reg_rdata_q == 0 && pwm_out_q == 0)
		else $error("outputs not quiet in reset");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == 8'h00) else $error("stray read data");
	a_reg_readback: assert property (reg_rd && rw |=> reg_rdata_q == $past(exp_rd))
		else $error("register readback wrong");
	a_outstat_read: assert property (reg_rd && reg_addr == 5 |=> reg_rdata_q == $past(pwm_out_q))
		else $error("status readback wrong");
	a_unmapped_zero: assert property (reg_rd && (reg_addr > 31 || reg_addr[5:1] == 3)
		|=> reg_rdata_q == 8'h00) else $error("unmapped read not zero");
	a_idle_level: assert property (quiet |-> ((pwm_out_q ^ ~pol) & idle) == 0)
		else $error("idle channel not inactive");
	a_full_active: assert property (quiet |-> ((pwm_out_q ^ pol) & act) == 0)
		else $error("full duty not active");
	a_join_even: assert property (quiet |-> ((pwm_out_q ^ ~pol) & jm) == 0)
		else $error("joined even channel active");
endmodule // pwm_timer_properties
bind pwm_timer pwm_timer_properties chk (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.pwm_out_q(pwm_out_q));

//--- sim/pwm_timer_tb.sv
// Bench: register tasks and measured high time of each channel
`timescale 1ns/100ps
module pwm_timer_tb;
	reg clk_sys = 0;
	reg rst = 0;
	reg [5:0] reg_addr = 0;
	reg [7:0] reg_wdata = 0;
	reg reg_wr = 0;
	reg reg_rd = 0;
	reg clr = 0;
	wire [7:0] reg_rdata_q, pwm_out_q;
	wire [127:0] hi_cnt;
	integer n_fail = 0;
	integer checks_done = 0;
	integer i;
	// Expected high cycles per channel over the 800 cycle window
	reg [127:0] exp_hi = 128'h00c8_0000_00c8_0064_0320_0000_0258_00c8;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
	$display("mismatch %0t got %h want %h", $time, a, e); end end
	pwm_timer dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .pwm_out_q(pwm_out_q));
	pwm_load ld (.clk_sys(clk_sys), .clr(clr), .pwm_out_q(pwm_out_q), .hi_cnt(hi_cnt));
	initial forever #5 clk_sys = ~clk_sys;
	task wr(input [5:0] a, input [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk_sys);
		reg_wr <= 0;
	endtask
	task rd(input [5:0] a, input [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk_sys);
		reg_rd <= 0;
		#1 `CHK(reg_rdata_q, e)
	endtask
	task summarize;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Watchdog
	initial begin
		#60000;
		n_fail++;
		$display("mismatch %0t timeout", $time);
		summarize;
	end
	// Reset values, refused writes, then one setting per channel
	initial begin
		rst <= 1;
		repeat (20) @(posedge clk_sys);
		rst <= 0;
		wr(5, 8'h5a);
		wr(6'h20, 8'h33);
		for (i = 0; i < 24; i++) rd(i[5:0], (i == 1 || i / 8 == 1) ? 8'hff : 8'h00);
		rd(6'h3f, 8'h00);
		wr(1, 8'hfd);
		wr(2, 8'h10);
		wr(3, 8'h08);
		wr(4, 8'h20);
		for (i = 0; i < 8; i++) wr(8 + i, 64'h0008_0404_0404_0404 >> (8 * i));
		for (i = 0; i < 8; i++) wr(16 + i, 64'h0002_0101_0500_0101 >> (8 * i));
		wr(0, 8'hff);
		rd(3, 8'h08);
		repeat (20) @(posedge clk_sys);
		clr <= 1;
		@(posedge clk_sys);
		clr <= 0;
		repeat (800) @(posedge clk_sys);
		#1;
		for (i = 0; i < 8; i++)
			`CHK(hi_cnt[16*i+:16], exp_hi[16*i+:16])
		wr(0, 8'h0f);
		// Disabled counters rest at zero, joined pair included
		for (i = 28; i < 32; i++) rd(i[5:0], 8'h00);
		repeat (620) @(posedge clk_sys);
		summarize;
	end
endmodule // pwm_timer_tb
